// ---- bench/pml_cpu_model.sv ----
/* CPU core, interrupt source and debug host model.
   Expects one-cycle op codes from the bench on ref_clk. */
`timescale 1ns/1ps
module pml_cpu_model (
   input  logic       ref_clk,           // Bus clock.
   input  logic [1:0] op,                // 1 WAIT, 2 STOP, 3 background.
   input  logic       irq_req,           // Raise an interrupt.
   input  logic       fetch_isr,         // Vector taken.
   output logic       cpu_wait_exec,     // WAIT pulse.
   output logic       cpu_stop_exec,     // STOP pulse.
   output logic       bdm_bkgd_cmd,      // Background pulse.
   output logic       irq_any = 1'b0     // Pending interrupt.
);
   // Instruction and command pulses; the host sends only allowed ones.
   assign cpu_wait_exec = (op == 2'h1);
   assign cpu_stop_exec = (op == 2'h2);
   assign bdm_bkgd_cmd  = (op == 2'h3);
   // The service routine clears its source once the vector is taken.
   always @(posedge ref_clk)
      irq_any <= irq_req | (irq_any & ~fetch_isr);
endmodule : pml_cpu_model

// ---- bench/pml_power_ctrl_sva.sv ----
/* Port assertions for the power sequencer.
   Bound into pml_power_ctrl; sees its ports only. */
`timescale 1ns/1ps
module pml_power_ctrl_sva (
   input logic        ref_clk,         // Clock.
   input logic        rst_b,           // Reset.
   input logic        cpu_wait_exec,   // WAIT.
   input logic        cpu_stop_exec,   // STOP.
   input logic        irq_any,         // Interrupt.
   input logic        bdm_bkgd_cmd,    // Background.
   input logic        bdm_status_cmd,  // Status command.
   input logic        por_det,         // Power-on level.
   input logic        cpu_clk_en,      // CPU clock.
   input logic        bus_clk_en,      // Bus clock.
   input logic        clr_i_mask,      // Mask clear.
   input logic        fetch_reset_vec, // Reset fetch.
   input logic [15:0] reset_vec_addr,  // Vector.
   input logic        fetch_isr,       // Vector fetch.
   input logic        bdm_err,         // Error.
   input logic        bdm_err_stop,    // Error in stop.
   input logic        clkgen_standby,  // Clock standby.
   input logic [15:0] mod_standby,     // Standby vector.
   input logic        sys_reset_b      // System reset.
);
   // All checks run on the bus clock and rest while reset is low.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_mask_clear: assert property ((cpu_wait_exec || cpu_stop_exec) |=> clr_i_mask)
      else $error("mask clear missing");
   a_vec_fixed: assert property (reset_vec_addr == 16'hFFFE)
      else $error("reset vector wrong");
   a_vec_after_reset: assert property ($rose(sys_reset_b) |-> ##[0:1] fetch_reset_vec)
      else $error("no reset fetch");
   a_wait_gates_cpu: assert property (cpu_wait_exec && cpu_clk_en && !bdm_bkgd_cmd |-> ##2 !cpu_clk_en)
      else $error("cpu clock not gated");
   a_wait_irq_wake: assert property (irq_any && !cpu_clk_en && bus_clk_en && sys_reset_b
      && $past(sys_reset_b, 2) && !bdm_bkgd_cmd && !$past(bdm_bkgd_cmd)
      |-> ##[0:2] fetch_isr)
      else $error("no wake on interrupt");
   a_stop_status_err: assert property (bdm_status_cmd && !bus_clk_en && sys_reset_b
      && !fetch_isr && !$past(bdm_bkgd_cmd) |=> bdm_err && bdm_err_stop)
      else $error("no stop error");
   a_stop_standby: assert property (!bus_clk_en && sys_reset_b |-> clkgen_standby
      && (mod_standby & pml_pkg::STOP_SBY) == pml_pkg::STOP_SBY)
      else $error("stop standby wrong");
   a_por_holds: assert property (por_det [*5] |-> !sys_reset_b)
      else $error("reset not held");
   cover property (fetch_isr);
   cover property (bdm_err && bdm_err_stop);
   cover property (!bus_clk_en && sys_reset_b);
endmodule : pml_power_ctrl_sva

bind pml_power_ctrl pml_power_ctrl_sva u_sva (.*);

// ---- bench/pml_power_ctrl_tb.sv ----
/* Self-checking bench for the power sequencer.
   Uses the CPU model as far side and the bound checker. */
`timescale 1ns/1ps
module pml_power_ctrl_tb;
   logic ref_clk = 0, rst_b = 0, por_det = 0, lvd_det = 0, lvw_det = 0, irq_req = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, bdm_status_cmd = 0, bdm_other_cmd = 0, bdm_go = 0;
   logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0, reset_vec_addr, mod_standby;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
   logic [7:0] stop_wake = 0, p1, p2, t;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, lvw_trip, op = 0, r;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic cpu_wait_exec, cpu_stop_exec, irq_any, bdm_bkgd_cmd, cpu_clk_en, bus_clk_en;
   logic clr_i_mask, fetch_reset_vec, fetch_isr, bdm_active, bdm_clk_en, bdm_accept;
   logic bdm_err, bdm_err_stop, reg_standby, clkgen_standby, osc_on, irclk_on;
   logic rtc_clk_en, lvd_on, lvd_trip_hi, bandgap_en, lvw_irq, sys_reset_b;
   int mismatches = 0, compares = 0, i;
   // Design, far-side model and bus clock.
   pml_power_ctrl dut (.*);
   pml_cpu_model  cpu (.*);
   always #20 ref_clk = ~ref_clk;
   // Compare, count and report.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      if (mismatches == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // Bounded wait for a flag at the rising edge.
   task automatic wt(ref logic s);
      for (int n = 0; s !== 1'b1; n++)
      begin
         if (n > 60)
         begin
            mismatches++;
            summarize();
         end
         @(posedge ref_clk);
      end
   endtask : wt
   // One AXI4-Lite write or read of register index idx.
   task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
      @(posedge ref_clk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {idx << 2, idx << 2, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      for (int n = 0; !(s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready); n++)
      begin
         if (n > 40)
         begin
            mismatches++;
            summarize();
         end
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      {q, r} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
      {s_axi_bready, s_axi_rready} <= 2'h0;
   endtask : bus
   // One-cycle instruction, interrupt or status command, then n edges.
   task automatic act(input logic [1:0] o, input logic iq, input logic st, input int n);
      @(posedge ref_clk);
      {op, irq_req, bdm_status_cmd} <= {o, iq, st};
      @(posedge ref_clk);
      {op, irq_req, bdm_status_cmd} <= 4'h0;
      repeat (n) @(posedge ref_clk);
   endtask : act
   // Main sequence.
   initial
   begin
      i = $urandom(88);
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      wt(sys_reset_b);
      bus(0, pml_pkg::PSC1_IDX, 0); chk(q, 32'h1C);
      bus(0, pml_pkg::STAT_IDX, 0); chk(q[3:0], 4'h3);
      bus(0, 16'h3050, 0); chk(r, pml_pkg::RESP_SLV);
      {p1, p2} = 16'($urandom) | 16'h0400; // Detect stays on for the later checks.
      bus(1, pml_pkg::PSC1_IDX, p1); bus(1, pml_pkg::PSC1_IDX, p2);
      bus(0, pml_pkg::PSC1_IDX, 0); chk(q, (p2 & 8'h29) | (p1 & 8'h14));
      chk({lvd_on, bandgap_en}, {p1[2], p2[0]});
      for (i = 0; i < 4; i++)
      begin
         t = 8'($urandom) & 8'h10 | 8'(i);
         bus(1, pml_pkg::PSC2_IDX, t); chk({lvd_trip_hi, lvw_trip}, {t[4], t[1:0]});
      end
      t = 8'($urandom) & 8'h1C;
      bus(1, pml_pkg::CTRL_IDX, t); act(2, 0, 0, 3); chk(bus_clk_en, 1);
      chk(rtc_clk_en, t[4:2] != 0);
      act(1, 0, 0, 3); chk({cpu_clk_en, bus_clk_en, mod_standby}, {2'h1, pml_pkg::WAIT_SBY});
      act(0, 0, 1, 1); chk({bdm_err, bdm_err_stop}, 2'h2);
      act(0, 1, 0, 0); wt(fetch_isr); act(0, 0, 0, 2); chk(cpu_clk_en, 1);
      bus(1, pml_pkg::CTRL_IDX, t | 8'h1); act(2, 0, 0, 3);
      chk({bus_clk_en, clkgen_standby, osc_on, irclk_on, bdm_clk_en}, 5'h08);
      chk({reg_standby, lvd_on}, {!(p1[2] & p2[3]), p1[2] & p2[3]});
      act(0, 0, 1, 1); chk({bdm_err, bdm_err_stop}, 2'h3);
      stop_wake <= 8'h1 << ($urandom % 8);
      wt(fetch_isr); stop_wake <= 8'h0; act(0, 0, 0, 2); chk(bus_clk_en, 1);
      lvw_det <= 1'b1; act(0, 0, 0, 4); bus(1, pml_pkg::PSC1_IDX, p2 | 8'h40);
      bus(0, pml_pkg::PSC1_IDX, 0); chk({q[7], lvw_irq}, {1'b1, p2[5]});
      lvw_det <= 1'b0; act(0, 0, 0, 4); bus(1, pml_pkg::PSC1_IDX, p2 | 8'h40);
      bus(0, pml_pkg::PSC1_IDX, 0); chk({q[7], lvw_irq}, 2'h0);
      act(1, 0, 0, 3); act(3, 0, 0, 2); chk(bdm_active, 1);
      act(0, 0, 1, 1); chk({bdm_accept, bdm_err}, 2'h2);
      bus(1, pml_pkg::STAT_IDX, 3); bus(0, pml_pkg::STAT_IDX, 0); chk(q[1:0], 0);
      lvd_det <= 1'b1; act(0, 0, 0, 6); chk(sys_reset_b, !p1[4]);
      lvd_det <= 1'b0; wt(sys_reset_b);
      bus(0, pml_pkg::STAT_IDX, 0); chk(q[1:0], {p1[4], 1'b0});
      por_det <= 1'b1; act(0, 0, 0, 8); chk(sys_reset_b, 0);
      por_det <= 1'b0; wt(sys_reset_b);
      bus(0, pml_pkg::STAT_IDX, 0); chk(q[1:0], 2'h3);
      summarize();
   end
endmodule : pml_power_ctrl_tb

// ---- hdl/pml_pkg.sv ----
/*
 * Constants, register map and types shared by the power mode and
 * low-voltage sequencer.
 * Assumes a 32-bit AXI4-Lite register bus with one register per word.
 */
package pml_pkg;

   // Register indices; byte address is four times the index.
   localparam logic [15:0] PSC1_IDX   = 16'h3040;
   localparam logic [15:0] PSC2_IDX   = 16'h3041;
   localparam logic [15:0] CTRL_IDX   = 16'h3042;
   localparam logic [15:0] STAT_IDX   = 16'h3043;

   // Reset values.
   localparam logic [7:0]  PSC1_RST   = 8'h1C;
   localparam logic [7:0]  PSC2_RST   = 8'h00;
   localparam logic [11:0] CTRL_RST   = 12'h000;

   // Fields of power_status_control_1.
   localparam int WFLAG_B  = 7;
   localparam int WACK_B   = 6;
   localparam int WIE_B    = 5;
   localparam int DRE_B    = 4;
   localparam int DSE_B    = 3;
   localparam int DE_B     = 2;
   localparam int BGE_B    = 0;

   // Fields of power_status_control_2.
   localparam int DTS_B    = 4;
   localparam int WTS_LO   = 0;

   // Fields of the control register.
   localparam int STOP_ENABLE_BIT_B  = 0;
   localparam int DBGE_B   = 1;
   localparam int RTC_PRESCALER_SELECT_LO = 2;
   localparam int OSCK_B   = 5;
   localparam int IRCK_B   = 6;
   localparam int KEEP_LO  = 8;

   // Fields of the status register.
   localparam int PORS_B   = 0;
   localparam int LVRS_B   = 1;
   localparam int MODE_LO  = 2;
   localparam int LVDS_B   = 4;
   localparam int LVWS_B   = 5;

   // Reset vector address and AXI responses.
   localparam logic [15:0] RESET_VEC  = 16'hFFFE;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;

   // Module standby vector: flash 0, ram 1, adc 2, acmp 3, tsi 4, sci 5,
   // spi 6, iic 7, ftm 8, mtim 9, wdog 10, dbg 11, ipc 12, crc 13,
   // rtc 14, lvd 15.
   localparam int          NMOD       = 16;
   localparam logic [15:0] WAIT_SBY   = 16'h0002;
   localparam logic [15:0] STOP_SBY   = 16'h3BE3;
   localparam logic [15:0] STOP_OPT   = 16'hC41C;
   localparam int ADC_M  = 2;
   localparam int ACMP_M = 3;
   localparam int TSI_M  = 4;
   localparam int WDOG_M = 10;
   localparam int RTC_M  = 14;
   localparam int LVD_M  = 15;

   typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_STOP3, PM_BDM} pml_mode_e;

endpackage : pml_pkg

// ---- hdl/pml_power_ctrl.sv ----
/*
 * Power mode sequencer with low-voltage detect and warning control.
 * Assumes rst_b comes only from the power-on cell, comparator outputs are
 * asynchronous, and CPU, debug and interrupt inputs are on ref_clk.
 */
`timescale 1ns/1ps
module pml_power_ctrl #(
   parameter int ADDR_W = 16,   // AXI address width.
   parameter int NWAKE  = 8     // Number of stop3 wake sources.
) (
   input  wire logic                 ref_clk,           // Bus clock, 25 MHz.
   input  wire logic                 rst_b,             // Power-on reset, active low.
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,      // Write address.
   input  wire logic                 s_axi_awvalid,     // Write address valid.
   output logic                      s_axi_awready,     // Write address ready.
   input  wire logic [31:0]          s_axi_wdata,       // Write data.
   input  wire logic [3:0]           s_axi_wstrb,       // Write strobes.
   input  wire logic                 s_axi_wvalid,      // Write data valid.
   output logic                      s_axi_wready,      // Write data ready.
   output logic [1:0]                s_axi_bresp,       // Write response.
   output logic                      s_axi_bvalid,      // Write response valid.
   input  wire logic                 s_axi_bready,      // Write response ready.
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,      // Read address.
   input  wire logic                 s_axi_arvalid,     // Read address valid.
   output logic                      s_axi_arready,     // Read address ready.
   output logic [31:0]               s_axi_rdata,       // Read data.
   output logic [1:0]                s_axi_rresp,       // Read response.
   output logic                      s_axi_rvalid,      // Read data valid.
   input  wire logic                 s_axi_rready,      // Read data ready.
   input  wire logic                 por_det,           // Supply below power-on level.
   input  wire logic                 lvd_det,           // Supply below detect trip.
   input  wire logic                 lvw_det,           // Supply below warning trip.
   input  wire logic                 cpu_wait_exec,     // WAIT executed, pulse.
   input  wire logic                 cpu_stop_exec,     // STOP executed, pulse.
   input  wire logic                 irq_any,           // Any pending interrupt.
   input  wire logic [NWAKE-1:0]     stop_wake,         // Stop3 wake interrupts.
   input  wire logic                 bdm_bkgd_cmd,      // Background command, pulse.
   input  wire logic                 bdm_status_cmd,    // Access-with-status, pulse.
   input  wire logic                 bdm_other_cmd,     // Any other command, pulse.
   input  wire logic                 bdm_go,            // Leave debug mode, pulse.
   output logic                      cpu_clk_en,        // CPU clock enable.
   output logic                      bus_clk_en,        // Bus clocks enable.
   output logic                      clr_i_mask,        // Clear CONDITION_CODE_REGISTER mask, pulse.
   output logic                      fetch_reset_vec,   // Take reset vector, pulse.
   output logic [15:0]               reset_vec_addr,    // Reset vector address.
   output logic                      fetch_isr,         // Take interrupt vector, pulse.
   output logic                      bdm_active,        // Active background mode.
   output logic                      bdm_clk_en,        // Debug logic clock enable.
   output logic                      bdm_accept,        // Command accepted, pulse.
   output logic                      bdm_err,           // Status error, pulse.
   output logic                      bdm_err_stop,      // Error flags stop, else wait.
   output logic                      reg_standby,       // Regulator in standby.
   output logic                      clkgen_standby,    // Clock generator standby.
   output logic                      osc_on,            // Oscillator running.
   output logic                      irclk_on,          // Reference clock running.
   output logic [pml_pkg::NMOD-1:0]  mod_standby,       // Per-module standby.
   output logic                      rtc_clk_en,        // RTC clock from LOW_POWER_OSCILLATOR.
   output logic                      lvd_on,            // Detect circuit enabled.
   output logic                      lvd_trip_hi,       // Detect trip high.
   output logic [1:0]                lvw_trip,          // Warning trip level.
   output logic                      bandgap_en,        // Bandgap buffer enable.
   output logic                      lvw_irq,           // Warning interrupt.
   output logic                      sys_reset_b        // System reset, active low.
);

   // Power mode and stop context captured at STOP.
   pml_pkg::pml_mode_e mode;
   pml_pkg::pml_mode_e next_mode;
   logic               stop_dbg;
   logic               stop_lvd;

   // Registers.
   logic [7:0]  psc1;
   logic [7:0]  psc2;
   logic [11:0] ctrl;
   logic        lvd_locked;
   logic        por_status;
   logic        lvr_status;
   logic        hold_rst;
   logic        boot;

   // Synchronizers for comparator outputs.
   logic [2:0]  cmp_m;
   logic [2:0]  cmp_s;

   // Bus slave state.
   logic              aw_got;
   logic              w_got;
   logic [ADDR_W-1:0] aw_q;
   logic [31:0]       w_q;
   logic [3:0]        ws_q;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
      hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction : hit

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, pml_pkg::PSC1_IDX) || hit(a, pml_pkg::PSC2_IDX) ||
               hit(a, pml_pkg::CTRL_IDX) || hit(a, pml_pkg::STAT_IDX);
   endfunction : mapped

   // Comparators are asynchronous, so two flops precede any use.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmp_m <= 3'h0;
         cmp_s <= 3'h0;
      end
      else
      begin
         cmp_m <= {lvw_det, lvd_det, por_det};
         cmp_s <= cmp_m;
      end
   end

   wire por_s = cmp_s[0];
   wire lvd_s = cmp_s[1];
   wire lvw_s = cmp_s[2];

   // Write path decode.
   wire wr_go   = aw_got && w_got && !s_axi_bvalid;
   wire wr_lane = ws_q[0];
   wire wr_psc1 = wr_go && wr_lane && hit(aw_q, pml_pkg::PSC1_IDX);
   wire wr_psc2 = wr_go && wr_lane && hit(aw_q, pml_pkg::PSC2_IDX);
   wire wr_ctrl = wr_go && wr_lane && hit(aw_q, pml_pkg::CTRL_IDX);
   wire wr_stat = wr_go && wr_lane && hit(aw_q, pml_pkg::STAT_IDX);

   // Control fields.
   wire       low_volt_detect_enable    = psc1[pml_pkg::DE_B];
   wire       detect_reset_enable   = psc1[pml_pkg::DRE_B];
   wire       detect_in_stop_enable   = psc1[pml_pkg::DSE_B];
   wire       stop_enable_bit   = ctrl[pml_pkg::STOP_ENABLE_BIT_B];
   wire       debug_enable_bit   = ctrl[pml_pkg::DBGE_B];
   wire [2:0] rtc_prescaler_select   = ctrl[pml_pkg::RTC_PRESCALER_SELECT_LO +: 3];
   wire [3:0] keep    = ctrl[pml_pkg::KEEP_LO +: 4];
   wire       in_stop = (mode == pml_pkg::PM_STOP3);
   wire       in_wait = (mode == pml_pkg::PM_WAIT);
   wire       low_pwr = in_stop || in_wait;

   // Detect runs only when enabled, and in stop only when kept or when debug was enabled at STOP.
   wire lvd_act  = low_volt_detect_enable && (!in_stop || stop_lvd || stop_dbg);
   wire lvd_rst  = lvd_act && detect_reset_enable && lvd_s;
   wire lvw_set  = lvd_act && lvw_s;
   wire lvw_ack  = wr_psc1 && w_q[pml_pkg::WACK_B] && !lvw_s;
   wire stop_ok  = cpu_stop_exec && stop_enable_bit;
   wire wake_any = |stop_wake;

   // Mode transitions.
   always_comb
   begin
      next_mode = mode;
      case (mode)
         pml_pkg::PM_RUN:
         begin
            if (bdm_bkgd_cmd && debug_enable_bit)
               next_mode = pml_pkg::PM_BDM;
            else if (cpu_wait_exec)
               next_mode = pml_pkg::PM_WAIT;
            else if (stop_ok)
               next_mode = pml_pkg::PM_STOP3;
         end
         pml_pkg::PM_WAIT:
         begin
            if (bdm_bkgd_cmd)
               next_mode = pml_pkg::PM_BDM;
            else if (irq_any)
               next_mode = pml_pkg::PM_RUN;
         end
         pml_pkg::PM_STOP3:
         begin
            if (bdm_bkgd_cmd && stop_dbg)
               next_mode = pml_pkg::PM_BDM;
            else if (wake_any)
               next_mode = pml_pkg::PM_RUN;
         end
         pml_pkg::PM_BDM:
         begin
            if (bdm_go)
               next_mode = pml_pkg::PM_RUN;
         end
         default: next_mode = pml_pkg::PM_RUN;
      endcase
   end

   // Interrupt wake from wait or stop leads into the service routine.
   wire isr_wake = (in_wait && !bdm_bkgd_cmd && irq_any) ||
                   (in_stop && !(bdm_bkgd_cmd && stop_dbg) && wake_any);

   // Mode state; state, registers and RAM are untouched in stop.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode     <= pml_pkg::PM_RUN;
         stop_dbg <= 1'b0;
         stop_lvd <= 1'b0;
         boot     <= 1'b1;
      end
      else
      begin
         mode <= hold_rst ? pml_pkg::PM_RUN : next_mode;
         boot <= hold_rst;
         if (mode == pml_pkg::PM_RUN && stop_ok)
         begin
            stop_dbg <= debug_enable_bit;
            stop_lvd <= low_volt_detect_enable && detect_in_stop_enable;
         end
      end
   end

   // Reset hold from power-on or enabled detect, with status capture.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hold_rst   <= 1'b1;
         por_status <= 1'b1;
         lvr_status <= 1'b1;
      end
      else
      begin
         if (por_s)
            hold_rst <= 1'b1;
         else if (lvd_rst)
            hold_rst <= 1'b1;
         else if (!lvd_s)
            hold_rst <= 1'b0;
         if (por_s)
            por_status <= 1'b1;
         else if (wr_stat && w_q[pml_pkg::PORS_B])
            por_status <= 1'b0;
         if (por_s || lvd_rst)
            lvr_status <= 1'b1;
         else if (wr_stat && w_q[pml_pkg::LVRS_B])
            lvr_status <= 1'b0;
      end
   end

   // Software registers; detect and detect reset enables are write-once, warning set wins.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         psc1       <= pml_pkg::PSC1_RST;
         psc2       <= pml_pkg::PSC2_RST;
         ctrl       <= pml_pkg::CTRL_RST;
         lvd_locked <= 1'b0;
      end
      else
      begin
         if (wr_psc1)
         begin
            psc1[pml_pkg::WIE_B] <= w_q[pml_pkg::WIE_B];
            psc1[pml_pkg::DSE_B] <= w_q[pml_pkg::DSE_B];
            psc1[pml_pkg::BGE_B] <= w_q[pml_pkg::BGE_B];
            lvd_locked           <= 1'b1;
            if (!lvd_locked)
            begin
               psc1[pml_pkg::DRE_B] <= w_q[pml_pkg::DRE_B];
               psc1[pml_pkg::DE_B]  <= w_q[pml_pkg::DE_B];
            end
         end
         if (lvw_set)
            psc1[pml_pkg::WFLAG_B] <= 1'b1;
         else if (lvw_ack)
            psc1[pml_pkg::WFLAG_B] <= 1'b0;
         if (wr_psc2)
         begin
            psc2[pml_pkg::DTS_B]      <= w_q[pml_pkg::DTS_B];
            psc2[pml_pkg::WTS_LO +: 2] <= w_q[pml_pkg::WTS_LO +: 2];
         end
         if (wr_ctrl)
            ctrl <= w_q[11:0];
      end
   end

   // Output values from the current mode and controls.
   wire [15:0] opt_keep = {lvd_act, (rtc_prescaler_select != 3'h0), 3'h0, keep[3], 5'h0,
                           keep[2], keep[1], keep[0], 2'h0};
   wire [15:0] next_sby = in_wait ? pml_pkg::WAIT_SBY :
                          in_stop ? (pml_pkg::STOP_SBY |
                                     (pml_pkg::STOP_OPT & ~opt_keep)) : 16'h0000;
   wire next_reg_sby = in_stop && !stop_dbg && !stop_lvd;
   wire low_cmd      = low_pwr && bdm_status_cmd;
   wire ok_cmd       = !low_pwr && (bdm_status_cmd || bdm_other_cmd);

   // Registered outputs.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cpu_clk_en      <= 1'b0;
         bus_clk_en      <= 1'b0;
         clr_i_mask      <= 1'b0;
         fetch_reset_vec <= 1'b0;
         fetch_isr       <= 1'b0;
         bdm_active      <= 1'b0;
         bdm_clk_en      <= 1'b0;
         bdm_accept      <= 1'b0;
         bdm_err         <= 1'b0;
         bdm_err_stop    <= 1'b0;
         reg_standby     <= 1'b0;
         clkgen_standby  <= 1'b0;
         osc_on          <= 1'b0;
         irclk_on        <= 1'b0;
         mod_standby     <= '0;
         rtc_clk_en      <= 1'b0;
         lvd_on          <= 1'b0;
         lvw_irq         <= 1'b0;
         sys_reset_b     <= 1'b0;
      end
      else
      begin
         cpu_clk_en      <= !low_pwr && !hold_rst;
         bus_clk_en      <= !in_stop;
         clr_i_mask      <= cpu_wait_exec || cpu_stop_exec;
         fetch_reset_vec <= boot && !hold_rst;
         fetch_isr       <= isr_wake;
         bdm_active      <= (mode == pml_pkg::PM_BDM);
         bdm_clk_en      <= !in_stop || stop_dbg;
         bdm_accept      <= ok_cmd;
         bdm_err         <= low_cmd;
         bdm_err_stop    <= low_cmd ? in_stop : bdm_err_stop;
         reg_standby     <= next_reg_sby;
         clkgen_standby  <= in_stop;
         osc_on          <= !in_stop || ctrl[pml_pkg::OSCK_B];
         irclk_on        <= !in_stop || ctrl[pml_pkg::IRCK_B];
         mod_standby     <= next_sby;
         rtc_clk_en      <= (rtc_prescaler_select != 3'h0);
         lvd_on          <= lvd_act;
         lvw_irq         <= psc1[pml_pkg::WFLAG_B] && psc1[pml_pkg::WIE_B] && low_volt_detect_enable;
         sys_reset_b     <= !hold_rst;
      end
   end

   assign reset_vec_addr = pml_pkg::RESET_VEC;   // Constant net, not logic.
   assign lvd_trip_hi    = psc2[pml_pkg::DTS_B];
   assign lvw_trip       = psc2[pml_pkg::WTS_LO +: 2];
   assign bandgap_en     = psc1[pml_pkg::BGE_B];

   // Write channel: address and data taken in either order, then response.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         aw_q          <= '0;
         w_q           <= 32'h0000_0000;
         ws_q          <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= pml_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_got && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_got && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got <= 1'b1;
            aw_q   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got <= 1'b1;
            w_q   <= s_axi_wdata;
            ws_q  <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_q) ? pml_pkg::RESP_OKAY : pml_pkg::RESP_SLV;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read data selection.
   wire [31:0] stat_word = {26'h0, lvw_s, lvd_s, mode, lvr_status, por_status};
   wire [31:0] rd_word =
      hit(s_axi_araddr, pml_pkg::PSC1_IDX) ? {24'h0, psc1 & 8'hBF} :
      hit(s_axi_araddr, pml_pkg::PSC2_IDX) ? {24'h0, psc2} :
      hit(s_axi_araddr, pml_pkg::CTRL_IDX) ? {20'h0, ctrl} :
      hit(s_axi_araddr, pml_pkg::STAT_IDX) ? stat_word : 32'h0000_0000;

   // Read channel: one cycle from address to data.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= pml_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= mapped(s_axi_araddr) ? pml_pkg::RESP_OKAY : pml_pkg::RESP_SLV;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule : pml_power_ctrl
